// [hw/tpm_master.sv]
// two-pin serial memory master: command register, buffer and bus sequencer
// What this block does
// - pins four and five become clock and data only while select equals 01.
// - firmware loads buffer, writes 0011; transmit starts, busy clears when done.
// - control bit 6 is busy, high while the bus is occupied, resets 0.
// - interrupt is raised when busy falls at the end of an operation.
// - bit 5 low means memory acknowledged last byte; resets to 1.
// - bit 4 low once the block has driven an acknowledge; resets to 1.
// - command 0010 receives a byte and drives acknowledge back.
// - command 0110 receives a last byte and leaves acknowledge undriven.
// - received byte lands in the buffer register at completion.
// - command 1001 makes a start condition, 0101 makes a stop condition.
// - command 0000 halts serial clock; otherwise clock keeps toggling.
// - undefined codes start nothing on the bus but set the clock high, and set error bit 7.
// - command field bits 3:0 write-only, resets 0000; status bits read-only.
// - serial clock runs at 78 kHz in transfers, rests high after a no-op.
`timescale 1ns/10ps
`default_nettype none
module tpm_master (
    input  wire logic       clk,          // system clock, 125 MHz
    input  wire logic       rst_n,        // sync reset, active low
    input  wire logic [1:0] memory_if_select, // interface select field
    input  wire logic       ctl_wr,       // control register write strobe
    input  wire logic [7:0] ctl_wdata,    // control write data
    output var  logic [7:0] ctl_rdata,    // control register read value
    input  wire logic       buf_wr,       // buffer register write strobe
    input  wire logic [7:0] buf_wdata,    // buffer write data
    output var  logic [7:0] buf_rdata,    // buffer register read value
    output var  logic       memory_if_interrupt, // pulse when busy falls
    input  wire logic       scl_i,        // pin four level (unused sense)
    output var  logic       scl_o,        // pin four output value
    output var  logic       scl_oe,       // pin four drive enable
    input  wire logic       sda_i,        // pin five level
    output var  logic       sda_o,        // pin five output value
    output var  logic       sda_oe        // pin five drive enable
);
    import tpm_pkg::*;

    typedef struct packed {
        tpm_state_t state;
        logic [3:0] cmd;
        logic [7:0] buffer;
        logic [7:0] shreg;
        logic [3:0] bitn;
        logic [1:0] phase;
        logic       rx;
        logic       ack_out;
        logic       err;
        logic       busy;
        logic       rxack_n;
        logic       txack_n;
        logic       scl;
        logic       sda_drv;
        logic       sck_run;
        logic       irq;
    } tpm_regs_t;

    tpm_regs_t st_q;
    tpm_regs_t st_d;
    logic      tick;
    logic      sel;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    function automatic logic cmd_legal(input logic [3:0] c);
        cmd_legal = (c == CMD_NOP) || (c == CMD_RX_ACK) || (c == CMD_TX) ||
                    (c == CMD_STOP) || (c == CMD_RX_LAST) || (c == CMD_START);
    endfunction

    assign sel = (memory_if_select == SEL_TWO_PIN);

    // quarter ticks only while something needs the clock to move
    tpm_quarter_tick u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (st_q.busy || st_q.sck_run),
        .tick  (tick)
    );

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        st_d.irq = 1'b0;
        if (buf_wr && !st_q.busy) begin
            st_d.buffer = buf_wdata;
        end
        case (st_q.state)
            TPM_IDLE: begin
                // free-running clock until a no-op stops it
                if (st_q.sck_run && tick && st_q.phase == 2'h1) begin
                    st_d.scl   = ~st_q.scl;
                end
                if (tick) begin
                    st_d.phase = st_q.phase + 2'h1;
                end
                if (ctl_wr && !st_q.busy) begin
                    st_d.cmd   = ctl_wdata[3:0];
                    st_d.phase = '0;
                    st_d.bitn  = '0;
                    st_d.scl   = 1'b1;
                    if (!cmd_legal(ctl_wdata[3:0])) begin
                        st_d.err = 1'b1;
                    end else begin
                        st_d.err = 1'b0;
                        case (ctl_wdata[3:0])
                            CMD_NOP: begin
                                st_d.sck_run = 1'b0;
                            end
                            CMD_START: begin
                                st_d.state   = TPM_START;
                                st_d.busy    = 1'b1;
                                st_d.sda_drv = 1'b1;
                                st_d.sck_run = 1'b1;
                            end
                            // clock goes low in the same cycle that data is pulled, so pulling data cannot look like a start
                            CMD_STOP: begin
                                st_d.state   = TPM_STOP;
                                st_d.busy    = 1'b1;
                                st_d.sda_drv = 1'b0;
                                st_d.scl     = 1'b0;
                                st_d.sck_run = 1'b1;
                            end
                            CMD_TX, CMD_RX_ACK, CMD_RX_LAST: begin
                                st_d.state   = TPM_SHIFT;
                                st_d.busy    = 1'b1;
                                st_d.sck_run = 1'b1;
                                st_d.rx      = (ctl_wdata[3:0] != CMD_TX);
                                st_d.ack_out = (ctl_wdata[3:0] == CMD_RX_ACK);
                                st_d.shreg   = st_q.buffer;
                                st_d.scl     = 1'b0;
                                st_d.sda_drv = 1'b0;
                            end
                            default: begin
                                st_d.state = TPM_IDLE;
                            end
                        endcase
                    end
                end
            end
            // q0 raises clock, q1 moves data while clock is high, q3 ends
            TPM_START, TPM_STOP: begin
                if (tick) begin
                    st_d.phase = st_q.phase + 2'h1;
                    if (st_q.phase == 2'h0) begin
                        st_d.scl = 1'b1;
                    end
                    if (st_q.phase == 2'h1) begin
                        st_d.sda_drv = (st_q.state == TPM_STOP);
                    end
                    if (st_q.phase == 2'h3) begin
                        st_d.scl   = (st_q.state == TPM_STOP);
                        st_d.state = TPM_IDLE;
                        st_d.busy  = 1'b0;
                    end
                end
            end
            // quarter 0 sets data, 1 raises clock, 2 samples, 3 lowers clock
            TPM_SHIFT: begin
                if (tick) begin
                    st_d.phase = st_q.phase + 2'h1;
                    case (st_q.phase)
                        2'h0: begin
                            if (st_q.bitn == BITS_LAST) begin
                                // ack slot: release for tx and final rx
                                st_d.sda_drv = st_q.rx ? ~st_q.ack_out : 1'b1;
                            end else begin
                                st_d.sda_drv = st_q.rx ? 1'b1 : st_q.shreg[7];
                            end
                        end
                        2'h1: st_d.scl = 1'b1;
                        2'h2: begin
                            if (st_q.bitn == BITS_LAST) begin
                                if (!st_q.rx) begin
                                    st_d.rxack_n = sda_i;
                                end else if (st_q.ack_out) begin
                                    st_d.txack_n = 1'b0;
                                end
                            end else begin
                                st_d.shreg = {st_q.shreg[6:0], sda_i};
                            end
                        end
                        2'h3: begin
                            st_d.scl  = 1'b0;
                            st_d.bitn = st_q.bitn + 4'h1;
                            if (st_q.bitn == BITS_LAST) begin
                                st_d.state   = TPM_IDLE;
                                st_d.busy    = 1'b0;
                                st_d.sda_drv = 1'b1;
                                // clock is left low for two quarter periods so the memory drops its ack without a stop
                                if (st_q.rx) begin
                                    st_d.buffer = st_q.shreg;
                                end
                            end
                        end
                        default: st_d.phase = st_q.phase;
                    endcase
                end
            end
            default: begin
                st_d.state = TPM_IDLE;
            end
        endcase
        // a busy fall is the only interrupt source
        if (st_q.busy && !st_d.busy) begin
            st_d.irq = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q         <= '0;
            st_q.state   <= TPM_IDLE;
            st_q.cmd     <= CMD_RESET;
            st_q.err     <= ERR_RESET;
            st_q.busy    <= BUSY_RESET;
            st_q.rxack_n <= RXACK_RESET;
            st_q.txack_n <= TXACK_RESET;
            st_q.scl     <= 1'b1;
            st_q.sda_drv <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs: command field reads as zero since it is write-only
    // ---------------------------------------------------------------
    assign ctl_rdata = {st_q.err, st_q.busy, st_q.rxack_n, st_q.txack_n, 4'h0};
    assign buf_rdata = st_q.buffer;
    assign memory_if_interrupt = st_q.irq;
    // open drain: high is released, low is driven
    assign scl_o  = 1'b0;
    assign scl_oe = sel && !st_q.scl;
    assign sda_o  = 1'b0;
    assign sda_oe = sel && !st_q.sda_drv;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    irq_on_fall_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $fell(st_q.busy) |-> memory_if_interrupt)
        else $error("interrupt missing on busy fall");
    tx_busy_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ctl_wr && !st_q.busy && ctl_wdata[3:0] == CMD_TX) |=> st_q.busy)
        else $error("transmit did not set busy");
    bad_cmd_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ctl_wr && !st_q.busy && !cmd_legal(ctl_wdata[3:0]))
        |=> ctl_rdata[CTL_ERR_BIT] && !st_q.busy)
        else $error("illegal command not flagged");
    pin_select_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sel |-> !scl_oe && !sda_oe)
        else $error("pins driven while not selected");
    idle_clock_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_q.state == TPM_IDLE && !st_q.sck_run) |-> st_q.scl)
        else $error("clock not resting high");
    busy_bit_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctl_rdata[CTL_BUSY_BIT] == (st_q.state != TPM_IDLE))
        else $error("busy bit wrong");
    last_noack_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_q.state == TPM_SHIFT && st_q.rx && !st_q.ack_out && st_q.bitn == BITS_LAST
         && st_q.phase != 2'h0) |-> !sda_oe)
        else $error("ack driven on last byte");
    cmd_hidden_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctl_rdata[3:0] == 4'h0)
        else $error("command field readable");
endmodule
`default_nettype wire

// [hw/tpm_pkg.sv]
// package: constants and types for the two-pin serial memory master
package tpm_pkg;
    // ---------------------------------------------------------------
    // register layout of serial_memory_control_status
    // ---------------------------------------------------------------
    localparam int          CTL_ERR_BIT   = 7;
    localparam int          CTL_BUSY_BIT  = 6;
    localparam int          CTL_RXACK_BIT = 5;
    localparam int          CTL_TXACK_BIT = 4;
    localparam logic [3:0]  CMD_RESET     = 4'h0;
    localparam logic        ERR_RESET     = 1'b0;
    localparam logic        BUSY_RESET    = 1'b0;
    localparam logic        RXACK_RESET   = 1'b1;
    localparam logic        TXACK_RESET   = 1'b1;
    localparam logic [1:0]  SEL_TWO_PIN   = 2'h1;

    // ---------------------------------------------------------------
    // command codes
    // ---------------------------------------------------------------
    localparam logic [3:0]  CMD_NOP       = 4'h0;
    localparam logic [3:0]  CMD_RX_ACK    = 4'h2;
    localparam logic [3:0]  CMD_TX        = 4'h3;
    localparam logic [3:0]  CMD_STOP      = 4'h5;
    localparam logic [3:0]  CMD_RX_LAST   = 4'h6;
    localparam logic [3:0]  CMD_START     = 4'h9;

    // ---------------------------------------------------------------
    // timing: serial clock 78 kHz from a 125 MHz system clock
    // ---------------------------------------------------------------
    localparam int          SYS_CLK_HZ    = 125000000;
    localparam int          SCK_HZ        = 78000;
    // quarter period, rounded down so the bus never runs slower than asked
    localparam int          QTR_CYC       = SYS_CLK_HZ / (SCK_HZ * 4);
    localparam logic [9:0]  QTR_LAST      = 10'(QTR_CYC - 1);
    localparam logic [3:0]  BITS_LAST     = 4'h8;   // 8 data + 1 ack

    typedef enum logic [2:0] {
        TPM_IDLE  = 3'b000,
        TPM_START = 3'b001,
        TPM_STOP  = 3'b010,
        TPM_SHIFT = 3'b011
    } tpm_state_t;
endpackage

// [hw/tpm_quarter_tick.sv]
// quarter-period tick generator for the serial clock
`timescale 1ns/10ps
`default_nettype none
module tpm_quarter_tick (
    input  wire logic clk,    // system clock
    input  wire logic rst_n,  // sync reset, active low
    input  wire logic run,    // count while high, clear otherwise
    output var  logic tick    // one-cycle pulse each quarter period
);
    import tpm_pkg::*;

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } tpm_tick_t;

    tpm_tick_t st_q;
    tpm_tick_t st_d;

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (!run) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == QTR_LAST) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule
`default_nettype wire

// [dv/tpm_eeprom_model.sv]
// behavioural serial memory standing on the far side of the two-pin master
`timescale 1ns/10ps
`default_nettype none
module tpm_eeprom_model (
    input  wire logic       clk,     // system clock, samples the lines
    input  wire logic       busy,    // byte window as firmware sees it
    input  wire logic [1:0] mode,    // 0 quiet, 1 ack, 2 nack, 3 send
    input  wire logic [7:0] tx_byte, // byte returned when mode is 3
    input  wire logic       scl,     // resolved clock line
    input  wire logic       sda,     // resolved data line
    output var  logic       sda_oe,  // high pulls data low
    output var  logic [7:0] got,     // last eight bits sampled
    output var  logic       ack_bit  // data level in the ninth clock
);
    logic       scl_q  = 1'b1;
    logic       busy_q = 1'b0;
    logic [3:0] cnt    = 4'h0;
    initial sda_oe  = 1'b0;
    initial got     = 8'h00;
    initial ack_bit = 1'b1;

    // --------------------------------------------------------------
    // bits count on rising edges; data moves only while clock is low
    // --------------------------------------------------------------
    always @(posedge clk) begin
        scl_q  <= scl;
        busy_q <= busy;
        if (busy && !busy_q) begin
            cnt    <= 4'h0;
            sda_oe <= (mode == 2'h3) && !tx_byte[7];
        end else if (!busy) begin
            sda_oe <= 1'b0;  // hold over: let the pull-up win
        end else if (scl && !scl_q) begin
            cnt <= cnt + 4'h1;
            if (cnt < 4'h8) got <= {got[6:0], sda};
            else if (cnt == 4'h8) ack_bit <= sda;
        end else if (!scl && scl_q) begin
            if (cnt == 4'h8) sda_oe <= (mode == 2'h1);
            else sda_oe <= (mode == 2'h3) && (cnt < 4'h8) && !tx_byte[3'h7 - cnt[2:0]];
        end
    end
endmodule
`default_nettype wire

// [dv/two_pin_eeprom_master_test.sv]
// self-checking bench for the two-pin serial memory master
`timescale 1ns/10ps
`default_nettype none
module two_pin_eeprom_master_test;
    import tpm_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [1:0] sel = SEL_TWO_PIN;
    logic       ctl_wr = 1'b0;
    logic       buf_wr = 1'b0;
    logic [7:0] ctl_wdata = 8'h00;
    logic [7:0] buf_wdata = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] ctl_rdata, buf_rdata, got;
    logic       irq, scl_o, scl_oe, sda_o, sda_oe, mdl_oe, ack_bit, scl_q, sda_q;
    int         num_errors = 0, comparisons = 0, irqs = 0, starts = 0, stops = 0;
    int         hi_cnt = 0, hi_len = 0, toggles = 0, leak = 0, t0;
    logic [3:0] bad [6] = '{4'h1, 4'h4, 4'h7, 4'h8, 4'ha, 4'hf};
    wire        scl, sda;

    // open-drain lines with pull-ups: any enabled low driver wins
    assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
    assign sda = ((sda_oe && !sda_o) || mdl_oe) ? 1'b0 : 1'b1;

    initial begin
        forever #4 clk = ~clk;
    end

    tpm_master u_tpm_master (.clk(clk), .rst_n(rst_n), .memory_if_select(sel),
        .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .buf_wr(buf_wr),
        .buf_wdata(buf_wdata), .buf_rdata(buf_rdata), .memory_if_interrupt(irq),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe));
    tpm_eeprom_model u_tpm_eeprom_model (.clk(clk), .busy(ctl_rdata[CTL_BUSY_BIT]),
        .mode(mode), .tx_byte(tx_byte), .scl(scl), .sda(sda), .sda_oe(mdl_oe),
        .got(got), .ack_bit(ack_bit));

    // --------------------------------------------------------------
    // line watcher: conditions, interrupts, clock high time
    // --------------------------------------------------------------
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (scl_q && scl && sda_q && !sda) starts <= starts + 1;
        if (scl_q && scl && !sda_q && sda) stops <= stops + 1;
        if (scl !== scl_q) toggles <= toggles + 1;
        if (sel != SEL_TWO_PIN && (scl_oe || sda_oe)) leak <= leak + 1;
        hi_cnt <= scl ? hi_cnt + 1 : 0;
        if (!scl && scl_q && ctl_rdata[CTL_BUSY_BIT]) hi_len <= hi_cnt;
    end

    task automatic check(input logic [15:0] act, input logic [15:0] exp);
        comparisons++;
        if (act !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one register write; which=1 selects the buffer
    task automatic wr(input logic which, input logic [7:0] d);
        @(posedge clk);
        ctl_wr    <= !which;
        buf_wr    <= which;
        ctl_wdata <= d;
        buf_wdata <= d;
        @(posedge clk);
        ctl_wr <= 1'b0;
        buf_wr <= 1'b0;
    endtask

    // command, busy seen, optional writes while busy, bounded wait for idle
    task automatic run(input logic [3:0] c, input logic [1:0] m, input logic poke);
        int n;
        mode <= m;
        wr(1'b0, {4'h0, c});
        repeat (2) @(posedge clk);
        check(16'(ctl_rdata[CTL_BUSY_BIT]), 16'h0001);
        if (poke) begin
            repeat (1000) @(posedge clk);
            wr(1'b0, {4'h0, CMD_STOP});
            wr(1'b1, 8'hff);
        end
        n = 0;
        while (ctl_rdata[CTL_BUSY_BIT] !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n == 20000) begin
            num_errors++;
            test_done();
        end
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(ctl_rdata, 8'h30);
        check({scl_oe, sda_oe}, 8'h00);
        // upper data bits try to set busy: status must stay read-only
        foreach (bad[i]) begin
            wr(1'b0, {4'h4, bad[i]});
            repeat (2) @(posedge clk);
            check(ctl_rdata, 8'hb0);
            check({scl_oe, sda_oe}, 8'h00);
        end
        $display("test illegal codes done");
        run(CMD_START, 2'h0, 1'b0);
        check(ctl_rdata, 8'h30);
        check(starts, 1);
        wr(1'b1, 8'ha6);
        run(CMD_TX, 2'h1, 1'b1);
        check(got, 8'ha6);
        check(buf_rdata, 8'ha6);
        check(ctl_rdata[CTL_RXACK_BIT], 1'b0);
        check(stops, 0);
        check(irqs, 2);
        check(hi_len[15:0], 16'(2 * QTR_CYC));
        t0 = toggles;
        repeat (2000) @(posedge clk);
        check(16'(toggles > t0), 16'h0001);
        wr(1'b0, {4'h0, CMD_NOP});
        repeat (4) @(posedge clk);
        t0 = toggles;
        repeat (2000) @(posedge clk);
        check({toggles == t0, scl}, 8'h03);
        $display("test transmit done");
        wr(1'b1, 8'h3c);
        run(CMD_TX, 2'h2, 1'b0);
        check(got, 8'h3c);
        check(ctl_rdata[CTL_RXACK_BIT], 1'b1);
        tx_byte <= 8'hc5;
        run(CMD_RX_ACK, 2'h3, 1'b0);
        check(buf_rdata, 8'hc5);
        check(ack_bit, 1'b0);
        check(ctl_rdata[CTL_TXACK_BIT], 1'b0);
        tx_byte <= 8'h3a;
        run(CMD_RX_LAST, 2'h3, 1'b0);
        check(buf_rdata, 8'h3a);
        check(ack_bit, 1'b1);
        $display("test receive done");
        run(CMD_STOP, 2'h0, 1'b0);
        check(stops, 1);
        check(irqs, 6);
        wr(1'b0, {4'h0, CMD_NOP});
        sel <= 2'h2;
        wr(1'b0, {4'h0, CMD_START});
        repeat (3000) @(posedge clk);
        check(leak, 0);
        $display("test pin select done");
        test_done();
    end
endmodule
`default_nettype wire
